// ---- design/pcs_core.sv ----
// Decided for this implementation: the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none

`include "pcs_map.svh"

// What this block does
// RULE_01: fifteen-bit counter, low byte writable, upper from latch
// RULE_02: every reset clears the whole counter
// RULE_03: low byte write loads upper latch together
// RULE_04: call loads eleven operand bits, latch bits above
// RULE_05: indirect call loads work register plus latch
// RULE_06: work-register branch adds one plus unsigned value
// RULE_07: immediate branch adds one plus signed operand
// RULE_08: sixteen fifteen-bit stack entries, own storage
// RULE_09: calls and interrupt vectoring push the counter
// RULE_10: all three returns pop into the counter; the code decodes only PCS_CMD_RETURN
// RULE_11: pushes and pops never touch the latch
// RULE_12: fault reset off: stack wraps circularly
// RULE_13: overflow and underflow flags always set
// RULE_14: fault reset on: reset and flag on fault
// RULE_15: index selects entry seen through top pair
// RULE_16: index is five bits for fault detection
// RULE_17: push increments then stores; pop loads then decrements
// RULE_18: index always names the last used entry
// RULE_19: context copies mapped readable and writable
// RULE_20: power-on reset leaves index at empty value
module pcs_core #(
	parameter logic [14:0] IRQ_VECTOR = `PCS_IRQ_VECTOR
) (
	input  wire logic                ref_clk,
	input  wire logic                rst_n,
	input  wire logic                soft_rst,
	input  wire logic                stack_fault_reset_cfg,
	input  wire pcs_pkg::pcs_req_t   req,
	input  wire pcs_pkg::pcs_core_t  core,
	input  wire logic                ctx_save,
	input  wire pcs_pkg::pcs_ctx_t   ctx_in,
	input  wire logic                over_flag_clr,
	input  wire logic                under_flag_clr,
	input  wire logic [13:0]         avs_address,
	input  wire logic                avs_read,
	input  wire logic                avs_write,
	input  wire logic [31:0]         avs_writedata,
	input  wire logic [3:0]          avs_byteenable,
	output logic [31:0]              avs_readdata,
	output logic                     avs_waitrequest,
	output var logic [14:0]          pc_q,
	output var logic [4:0]           stack_index_q,
	output var logic                 stack_over_flag_q,
	output var logic                 stack_under_flag_q,
	output var logic                 stack_fault_rst_q,
	output var pcs_pkg::pcs_ctx_t    ctx_shadow_q
);
	import pcs_pkg::*;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	// no reset on the entries: they read unknown until pushed, as real stacks do
	logic [14:0] stack_mem [16]; // [RULE_08]

	logic        push_w;
	logic        pop_w;
	logic        ovf_w;
	logic        unf_w;
	logic        fault_w;
	logic [14:0] pc_inc_w;
	logic [14:0] brw_w;
	logic [14:0] bra_w;
	logic [14:0] top_w;
	logic [3:0]  push_slot_w;

	logic        wait_q;
	logic [31:0] rd_data_q;
	logic        bus_req_w;
	logic        take_w;
	logic        wr_w;
	logic        aligned_w;
	logic [11:0] reg_idx_w;
	logic [7:0]  wr_byte_w;
	logic [7:0]  rd_byte_w;

	assign avs_readdata    = rd_data_q;
	assign avs_waitrequest = wait_q;

	always_comb
	begin
		push_w      = (req.cmd == PCS_CMD_CALL) || (req.cmd == PCS_CMD_CALL_W)
			|| (req.cmd == PCS_CMD_IRQ); // [RULE_09]
		pop_w       = (req.cmd == PCS_CMD_RETURN); // [RULE_10]
		ovf_w       = push_w && (stack_index_q == `PCS_STK_LAST); // [RULE_16]
		unf_w       = pop_w && (stack_index_q == `PCS_STK_EMPTY); // [RULE_16]
		fault_w     = stack_fault_reset_cfg && (ovf_w || unf_w) && !soft_rst; // [RULE_14]
		pc_inc_w    = pc_q + 15'h0001;
		brw_w       = pc_q + 15'h0001 + {7'h00, core.work_reg}; // [RULE_06]
		bra_w       = pc_q + 15'h0001 + {{6{req.operand[8]}}, req.operand[8:0]}; // [RULE_07]
		top_w       = stack_mem[stack_index_q[3:0]]; // [RULE_15]
		push_slot_w = stack_index_q[3:0] + 4'h1; // [RULE_12]
	end

	// bus: waitrequest drops one cycle after the request; a read is captured on that edge, a write lands on the next
	always_comb
	begin
		bus_req_w = avs_read || avs_write;
		take_w    = bus_req_w && !wait_q;
		aligned_w = (avs_address[1:0] == 2'b00);
		reg_idx_w = avs_address[13:2];
		wr_w      = avs_write && take_w && avs_byteenable[0] && aligned_w;
		wr_byte_w = avs_writedata[7:0];
	end

	always_comb
	begin
		rd_byte_w = 8'h00;
		if (!aligned_w)
			rd_byte_w = 8'h00;
		else if (reg_idx_w == `PCS_IDX_FLAGS_CTX)
			rd_byte_w = {5'h00, ctx_shadow_q.flags}; // [RULE_19]
		else if (reg_idx_w == `PCS_IDX_WORK_CTX)
			rd_byte_w = ctx_shadow_q.work_reg;
		else if (reg_idx_w == `PCS_IDX_BANK_CTX)
			rd_byte_w = {3'h0, ctx_shadow_q.bank_sel};
		else if (reg_idx_w == `PCS_IDX_PCLATCH_CTX)
			rd_byte_w = {1'b0, ctx_shadow_q.pc_high_latch};
		else if (reg_idx_w == `PCS_IDX_PTR0_LOW_CTX)
			rd_byte_w = ctx_shadow_q.ind_ptr0[7:0];
		else if (reg_idx_w == `PCS_IDX_PTR0_HIGH_CTX)
			rd_byte_w = ctx_shadow_q.ind_ptr0[15:8];
		else if (reg_idx_w == `PCS_IDX_PTR1_LOW_CTX)
			rd_byte_w = ctx_shadow_q.ind_ptr1[7:0];
		else if (reg_idx_w == `PCS_IDX_PTR1_HIGH_CTX)
			rd_byte_w = ctx_shadow_q.ind_ptr1[15:8];
		else if (reg_idx_w == `PCS_IDX_STACK_INDEX)
			rd_byte_w = {3'h0, stack_index_q}; // [RULE_18]
		else if (reg_idx_w == `PCS_IDX_STACK_TOP_LOW)
			rd_byte_w = top_w[7:0]; // [RULE_15]
		else if (reg_idx_w == `PCS_IDX_STACK_TOP_HIGH)
			rd_byte_w = {1'b0, top_w[14:8]}; // [RULE_15]
		else
			rd_byte_w = 8'h00;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			wait_q <= 1'b1;
		else if (take_w)
			wait_q <= 1'b1;
		else if (bus_req_w)
			wait_q <= 1'b0;
	end

	// read data is captured on the edge that drops waitrequest and held
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_q <= 32'h00000000;
		else if (bus_req_w && wait_q)
			rd_data_q <= {24'h000000, rd_byte_w};
	end

	// program counter
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pc_q <= `PCS_PC_RESET; // [RULE_02]
		else if (soft_rst || fault_w)
			pc_q <= `PCS_PC_RESET; // [RULE_02] [RULE_14]
		else
		begin
			case (req.cmd)
				PCS_CMD_ADVANCE:
					pc_q <= pc_inc_w;
				PCS_CMD_WRITE_LOW:
					pc_q <= {core.pc_high_latch, req.operand[7:0]}; // [RULE_01] [RULE_03]
				PCS_CMD_CALL:
					pc_q <= {core.pc_high_latch[6:3], req.operand}; // [RULE_04]
				PCS_CMD_CALL_W:
					pc_q <= {core.pc_high_latch, core.work_reg}; // [RULE_05]
				PCS_CMD_BR_W:
					pc_q <= brw_w; // [RULE_06]
				PCS_CMD_BR_IMM:
					pc_q <= bra_w; // [RULE_07]
				PCS_CMD_IRQ:
					pc_q <= IRQ_VECTOR; // [RULE_09]
				PCS_CMD_RETURN:
					pc_q <= top_w; // [RULE_10] [RULE_17]
				default:
					pc_q <= pc_q;
			endcase
		end
	end

	// stack index; core traffic wins over a software write in the same cycle
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stack_index_q <= `PCS_STK_EMPTY; // [RULE_20]
		else if (soft_rst || fault_w)
			stack_index_q <= `PCS_STK_EMPTY; // [RULE_14]
		else if (push_w)
			stack_index_q <= stack_index_q + 5'h01; // [RULE_17] [RULE_12]
		else if (pop_w)
			stack_index_q <= stack_index_q - 5'h01; // [RULE_17] [RULE_18]
		else if (wr_w && reg_idx_w == `PCS_IDX_STACK_INDEX)
			stack_index_q <= wr_byte_w[4:0]; // [RULE_15] [RULE_16]
	end

	// entries; the latch input is only read here, never written back
	always_ff @(posedge ref_clk)
	begin
		if (push_w && !fault_w && !soft_rst)
			stack_mem[push_slot_w] <= pc_q; // [RULE_17] [RULE_12] [RULE_11]
		else if (wr_w && reg_idx_w == `PCS_IDX_STACK_TOP_LOW)
			stack_mem[stack_index_q[3:0]][7:0] <= wr_byte_w; // [RULE_15]
		else if (wr_w && reg_idx_w == `PCS_IDX_STACK_TOP_HIGH)
			stack_mem[stack_index_q[3:0]][14:8] <= wr_byte_w[6:0]; // [RULE_15]
	end

	// flags survive the fault reset so software can see the cause; set beats clear
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stack_over_flag_q <= 1'b0;
		else if (ovf_w && !soft_rst)
			stack_over_flag_q <= 1'b1; // [RULE_13]
		else if (over_flag_clr)
			stack_over_flag_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stack_under_flag_q <= 1'b0;
		else if (unf_w && !soft_rst)
			stack_under_flag_q <= 1'b1; // [RULE_13]
		else if (under_flag_clr)
			stack_under_flag_q <= 1'b0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			stack_fault_rst_q <= 1'b0;
		else
			stack_fault_rst_q <= fault_w; // [RULE_14]
	end

	// context copies; a hardware save wins over a software write
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			ctx_shadow_q <= '0;
		else if (ctx_save)
			ctx_shadow_q <= ctx_in; // [RULE_19]
		else if (wr_w)
		begin
			if (reg_idx_w == `PCS_IDX_FLAGS_CTX)
				ctx_shadow_q.flags <= wr_byte_w[2:0]; // [RULE_19]
			else if (reg_idx_w == `PCS_IDX_WORK_CTX)
				ctx_shadow_q.work_reg <= wr_byte_w;
			else if (reg_idx_w == `PCS_IDX_BANK_CTX)
				ctx_shadow_q.bank_sel <= wr_byte_w[4:0];
			else if (reg_idx_w == `PCS_IDX_PCLATCH_CTX)
				ctx_shadow_q.pc_high_latch <= wr_byte_w[6:0];
			else if (reg_idx_w == `PCS_IDX_PTR0_LOW_CTX)
				ctx_shadow_q.ind_ptr0[7:0] <= wr_byte_w;
			else if (reg_idx_w == `PCS_IDX_PTR0_HIGH_CTX)
				ctx_shadow_q.ind_ptr0[15:8] <= wr_byte_w;
			else if (reg_idx_w == `PCS_IDX_PTR1_LOW_CTX)
				ctx_shadow_q.ind_ptr1[7:0] <= wr_byte_w;
			else if (reg_idx_w == `PCS_IDX_PTR1_HIGH_CTX)
				ctx_shadow_q.ind_ptr1[15:8] <= wr_byte_w;
		end
	end

	soft_reset_pc_a: assert property ( // [RULE_02]
		soft_rst |=> (pc_q == `PCS_PC_RESET) && (stack_index_q == `PCS_STK_EMPTY))
		else $error("counter not cleared by reset request");

	pc_low_write_a: assert property ( // [RULE_03]
		(req.cmd == PCS_CMD_WRITE_LOW) && !soft_rst
		|=> pc_q == {$past(core.pc_high_latch), $past(req.operand[7:0])})
		else $error("low byte write did not load full counter");

	call_load_a: assert property ( // [RULE_04]
		(req.cmd == PCS_CMD_CALL) && !soft_rst && !fault_w
		|=> pc_q == {$past(core.pc_high_latch[6:3]), $past(req.operand)})
		else $error("call target wrong");

	indirect_call_op_load_a: assert property ( // [RULE_05]
		(req.cmd == PCS_CMD_CALL_W) && !soft_rst && !fault_w
		|=> pc_q == {$past(core.pc_high_latch), $past(core.work_reg)})
		else $error("indirect call target wrong");

	brw_target_a: assert property ( // [RULE_06]
		(req.cmd == PCS_CMD_BR_W) && !soft_rst
		|=> pc_q == $past(pc_q) + 15'h0001 + {7'h00, $past(core.work_reg)})
		else $error("work register branch target wrong");

	bra_target_a: assert property ( // [RULE_07]
		(req.cmd == PCS_CMD_BR_IMM) && !soft_rst
		|=> pc_q == $past(pc_q) + 15'h0001
			+ {{6{$past(req.operand[8])}}, $past(req.operand[8:0])})
		else $error("immediate branch target wrong");

	irq_push_a: assert property ( // [RULE_09]
		(req.cmd == PCS_CMD_IRQ) && !soft_rst && !fault_w
		|=> (pc_q == IRQ_VECTOR) && (stack_mem[stack_index_q[3:0]] == $past(pc_q)))
		else $error("interrupt did not push and vector");

	pop_restore_a: assert property ( // [RULE_10]
		pop_w && !soft_rst && !fault_w
		|=> (pc_q == $past(top_w)) && (stack_index_q == $past(stack_index_q) - 5'h01))
		else $error("return did not restore counter");

	push_index_a: assert property ( // [RULE_17]
		push_w && !soft_rst && !fault_w
		|=> stack_index_q == $past(stack_index_q) + 5'h01)
		else $error("push did not step index");

	wrap_mode_a: assert property ( // [RULE_12]
		push_w && !stack_fault_reset_cfg && !soft_rst && (stack_index_q == `PCS_STK_LAST)
		|=> (stack_index_q == `PCS_STK_WRAP_FIRST) && stack_over_flag_q
			&& (stack_mem[4'h0] == $past(pc_q)))
		else $error("circular stack did not wrap");

	underflow_flag_a: assert property ( // [RULE_13]
		unf_w && !soft_rst |=> stack_under_flag_q)
		else $error("underflow flag not set");

	fault_reset_a: assert property ( // [RULE_14]
		fault_w |=> stack_fault_rst_q && (pc_q == `PCS_PC_RESET)
			&& (stack_index_q == `PCS_STK_EMPTY) ##1 !stack_fault_rst_q)
		else $error("stack fault reset wrong");

	overflow_flag_a: assert property ( // [RULE_13]
		ovf_w && !soft_rst |=> stack_over_flag_q)
		else $error("overflow flag not set");

	bus_answer_a: assert property ( // [RULE_19]
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered");

	ctx_save_a: assert property ( // [RULE_19]
		ctx_save |=> ctx_shadow_q == $past(ctx_in))
		else $error("context save not captured");

	index_write_a: assert property ( // [RULE_15]
		wr_w && (reg_idx_w == `PCS_IDX_STACK_INDEX) && !push_w && !pop_w && !soft_rst
		|=> stack_index_q == $past(wr_byte_w[4:0]))
		else $error("index write not applied");

	top_low_write_a: assert property ( // [RULE_15]
		wr_w && (reg_idx_w == `PCS_IDX_STACK_TOP_LOW) && !push_w && !pop_w && !soft_rst
		|=> stack_mem[stack_index_q[3:0]][7:0] == $past(wr_byte_w))
		else $error("top low write not applied");

	top_high_write_a: assert property ( // [RULE_15]
		wr_w && (reg_idx_w == `PCS_IDX_STACK_TOP_HIGH) && !push_w && !pop_w && !soft_rst
		|=> stack_mem[stack_index_q[3:0]][14:8] == $past(wr_byte_w[6:0]))
		else $error("top high write not applied");

	empty_push_a: assert property ( // [RULE_20]
		push_w && (stack_index_q == `PCS_STK_EMPTY) && !soft_rst
		|=> (stack_index_q == 5'h00) && (stack_mem[4'h0] == $past(pc_q)))
		else $error("first push did not land in entry zero");

	wrap_second_a: assert property ( // [RULE_12]
		push_w && !stack_fault_reset_cfg && !soft_rst && (stack_index_q == `PCS_STK_WRAP_FIRST)
		|=> (stack_index_q == 5'h11) && (stack_mem[4'h1] == $past(pc_q)))
		else $error("second wrapped push misplaced");

endmodule // pcs_core

`default_nettype wire

// ---- design/pcs_map.svh ----
`ifndef PCS_MAP_SVH
`define PCS_MAP_SVH

// register indices; the byte address on the bus is four times the index
`define PCS_IDX_FLAGS_CTX      12'hfe4
`define PCS_IDX_WORK_CTX       12'hfe5
`define PCS_IDX_BANK_CTX       12'hfe6
`define PCS_IDX_PCLATCH_CTX    12'hfe7
`define PCS_IDX_PTR0_LOW_CTX   12'hfe8
`define PCS_IDX_PTR0_HIGH_CTX  12'hfe9
`define PCS_IDX_PTR1_LOW_CTX   12'hfea
`define PCS_IDX_PTR1_HIGH_CTX  12'hfeb
`define PCS_IDX_STACK_INDEX    12'hfed
`define PCS_IDX_STACK_TOP_LOW  12'hfee
`define PCS_IDX_STACK_TOP_HIGH 12'hfef

// reset values and stack limits
`define PCS_PC_RESET           15'h0000
`define PCS_STK_EMPTY          5'h1f
`define PCS_STK_LAST           5'h0f
`define PCS_STK_WRAP_FIRST     5'h10
`define PCS_IRQ_VECTOR         15'h0004

`endif

// ---- design/pcs_pkg.sv ----
`default_nettype none

package pcs_pkg;

	typedef enum logic [3:0] {
		PCS_CMD_NONE,
		PCS_CMD_ADVANCE,
		PCS_CMD_WRITE_LOW,
		PCS_CMD_CALL,
		PCS_CMD_CALL_W,
		PCS_CMD_BR_W,
		PCS_CMD_BR_IMM,
		PCS_CMD_IRQ,
		PCS_CMD_RETURN
	} pcs_cmd_t;

	typedef struct packed {
		pcs_cmd_t    cmd;
		logic [10:0] operand;
	} pcs_req_t;

	typedef struct packed {
		logic [6:0] pc_high_latch;
		logic [7:0] work_reg;
	} pcs_core_t;

	typedef struct packed {
		logic [2:0]  flags;
		logic [7:0]  work_reg;
		logic [4:0]  bank_sel;
		logic [6:0]  pc_high_latch;
		logic [15:0] ind_ptr0;
		logic [15:0] ind_ptr1;
	} pcs_ctx_t;

endpackage

`default_nettype wire

// ---- test/pcs_core_tb.sv ----
`timescale 1ns/1ps
`default_nettype none

`include "pcs_map.svh"

`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin errors++; \
	$display("mismatch at %0t: got %h exp %h", $time, (a), (e)); end end

module pcs_core_tb;
	import pcs_pkg::*;

	logic        ref_clk = 1'b0, rst_n = 1'b0, soft_rst = 1'b0, cfg = 1'b0, clr = 1'b0;
	logic [13:0] avs_address = '0;
	logic        avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
	logic [31:0] avs_writedata = '0, avs_readdata;
	pcs_req_t    req;
	pcs_core_t   core;
	logic        ctx_save, ovf_q, unf_q, flt_q;
	pcs_ctx_t    ctx_in, ctx_q;
	logic [14:0] pc_q, epc = '0;
	logic [4:0]  idx_q, eidx = `PCS_STK_EMPTY;
	logic [14:0] stk [16];
	logic        eovf = 1'b0, eunf = 1'b0, eflt = 1'b0;
	logic [7:0]  rd;
	int          errors = 0, samples_checked = 0;
	logic [7:0]  eb [8] = '{8'h05, 8'ha1, 8'h12, 8'h33, 8'hc4, 8'hb2, 8'he8, 8'hd6};
	logic [7:0]  msk [8] = '{8'h07, 8'hff, 8'h1f, 8'h7f, 8'hff, 8'hff, 8'hff, 8'hff};

	always #2.5 ref_clk = ~ref_clk;

	pcs_cpu_model cpu (.ref_clk(ref_clk), .req(req), .core(core), .ctx_save(ctx_save),
		.ctx_in(ctx_in));

	pcs_core uut (.ref_clk(ref_clk), .rst_n(rst_n), .soft_rst(soft_rst),
		.stack_fault_reset_cfg(cfg), .req(req), .core(core), .ctx_save(ctx_save),
		.ctx_in(ctx_in), .over_flag_clr(clr), .under_flag_clr(clr),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .pc_q(pc_q), .stack_index_q(idx_q),
		.stack_over_flag_q(ovf_q), .stack_under_flag_q(unf_q),
		.stack_fault_rst_q(flt_q), .ctx_shadow_q(ctx_q));

	task automatic finish_test;
		if (errors == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// master holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [11:0] idx, input logic [7:0] wd);
		@(posedge ref_clk);
		avs_read <= ~wr;
		avs_write <= wr;
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, wd};
		// no local limit: a stuck slave is left to the watchdog
		do
		begin
			@(posedge ref_clk);
		end while (avs_waitrequest !== 1'b0);
		rd = avs_readdata[7:0];
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic rdchk(input logic [11:0] idx, input logic [7:0] e);
		bus(1'b0, idx, 8'h00);
		`CHK(rd, e)
		`CHK(avs_readdata[31:8], 24'h000000)
	endtask

	task automatic state_chk;
		#1;
		`CHK(pc_q, epc)
		`CHK(idx_q, eidx)
		`CHK({ovf_q, unf_q, flt_q}, {eovf, eunf, eflt})
	endtask

	// reference model of the counter and stack, updated before the command goes out
	task automatic op(input pcs_cmd_t c, input logic [10:0] opd);
		logic push, pop;
		push = c inside {PCS_CMD_CALL, PCS_CMD_CALL_W, PCS_CMD_IRQ};
		pop = (c == PCS_CMD_RETURN);
		eflt = cfg && ((push && eidx == `PCS_STK_LAST) || (pop && eidx == `PCS_STK_EMPTY));
		eovf |= push && eidx == `PCS_STK_LAST;
		eunf |= pop && eidx == `PCS_STK_EMPTY;
		if (eflt)
		begin
			epc = `PCS_PC_RESET;
			eidx = `PCS_STK_EMPTY;
		end
		else
		begin
			if (push)
			begin
				eidx++;
				stk[eidx[3:0]] = epc;
			end
			case (c)
				PCS_CMD_ADVANCE:   epc = epc + 15'h0001;
				PCS_CMD_WRITE_LOW: epc = {core.pc_high_latch, opd[7:0]};
				PCS_CMD_CALL:      epc = {core.pc_high_latch[6:3], opd};
				PCS_CMD_CALL_W:    epc = {core.pc_high_latch, core.work_reg};
				PCS_CMD_BR_W:      epc = epc + 15'h0001 + {7'h00, core.work_reg};
				PCS_CMD_BR_IMM:    epc = epc + 15'h0001 + {{6{opd[8]}}, opd[8:0]};
				PCS_CMD_IRQ:       epc = `PCS_IRQ_VECTOR;
				PCS_CMD_RETURN:
				begin
					epc = stk[eidx[3:0]];
					eidx--;
				end
				default: ;
			endcase
		end
		cpu.issue(c, opd);
		state_chk();
	endtask

	// s: soft reset, c: clear both flags
	task automatic ctl(input logic s, input logic c);
		@(posedge ref_clk);
		soft_rst <= s;
		clr <= c;
		@(posedge ref_clk);
		soft_rst <= 1'b0;
		clr <= 1'b0;
		if (s)
		begin
			epc = `PCS_PC_RESET;
			eidx = `PCS_STK_EMPTY;
		end
		if (c)
		begin
			eovf = 1'b0;
			eunf = 1'b0;
		end
		eflt = 1'b0;
		state_chk();
	endtask

	initial
	begin
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		state_chk();
		rdchk(`PCS_IDX_STACK_INDEX, 8'h1f);
		cpu.save({3'h5, 8'ha1, 5'h12, 7'h33, 16'hb2c4, 16'hd6e8});
		#1;
		`CHK(ctx_q, {3'h5, 8'ha1, 5'h12, 7'h33, 16'hb2c4, 16'hd6e8})
		for (int i = 0; i < 8; i++)
			rdchk(`PCS_IDX_FLAGS_CTX + 12'(i), eb[i]);
		for (int i = 0; i < 8; i++)
		begin
			bus(1'b1, `PCS_IDX_FLAGS_CTX + 12'(i), 8'hff);
			rdchk(`PCS_IDX_FLAGS_CTX + 12'(i), msk[i]);
		end
		bus(1'b1, 12'hfec, 8'hff);
		rdchk(12'hfec, 8'h00);
		cpu.set_core(7'h55, 8'h3c);
		op(PCS_CMD_WRITE_LOW, 11'h0ab);
		op(PCS_CMD_ADVANCE, 11'h000);
		op(PCS_CMD_CALL, 11'h7c3);
		op(PCS_CMD_CALL_W, 11'h000);
		op(PCS_CMD_BR_W, 11'h000);
		op(PCS_CMD_BR_IMM, 11'h100);
		op(PCS_CMD_BR_IMM, 11'h0ff);
		op(PCS_CMD_IRQ, 11'h000);
		rdchk(`PCS_IDX_STACK_INDEX, {3'h0, eidx});
		rdchk(`PCS_IDX_STACK_TOP_LOW, stk[eidx[3:0]][7:0]);
		rdchk(`PCS_IDX_STACK_TOP_HIGH, {1'b0, stk[eidx[3:0]][14:8]});
		repeat (3) op(PCS_CMD_RETURN, 11'h000);
		bus(1'b1, `PCS_IDX_STACK_INDEX, 8'h03);
		bus(1'b1, `PCS_IDX_STACK_TOP_LOW, 8'h9d);
		bus(1'b1, `PCS_IDX_STACK_TOP_HIGH, 8'h2e);
		eidx = 5'h03;
		stk[3] = 15'h2e9d;
		rdchk(`PCS_IDX_STACK_TOP_LOW, 8'h9d);
		op(PCS_CMD_RETURN, 11'h000);
		ctl(1'b1, 1'b0);
		for (int i = 0; i < 18; i++)
			op(PCS_CMD_CALL, 11'(i * 8'h11));
		repeat (19) op(PCS_CMD_RETURN, 11'h000);
		ctl(1'b0, 1'b1);
		@(posedge ref_clk) cfg <= 1'b1;
		ctl(1'b1, 1'b0);
		repeat (17) op(PCS_CMD_IRQ, 11'h000);
		op(PCS_CMD_RETURN, 11'h000);
		finish_test();
	end

	// whole run is a few hundred cycles; this cuts a hang
	initial
	begin
		#100000;
		errors++;
		finish_test();
	end
endmodule // pcs_core_tb

`undef CHK
`default_nettype wire

// ---- test/pcs_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none

// decoder and interrupt side; one idle cycle after each command keeps drives apart
module pcs_cpu_model (
	input  wire logic             ref_clk,
	output var  pcs_pkg::pcs_req_t  req,
	output var  pcs_pkg::pcs_core_t core,
	output var  logic             ctx_save,
	output var  pcs_pkg::pcs_ctx_t  ctx_in
);
	import pcs_pkg::*;

	initial
	begin
		req = '0;
		core = '0;
		ctx_save = 1'b0;
		ctx_in = '0;
	end

	task automatic issue(input pcs_cmd_t c, input logic [10:0] opd);
		@(posedge ref_clk);
		req <= {c, opd};
		@(posedge ref_clk);
		req <= {PCS_CMD_NONE, 11'h000};
	endtask

	task automatic set_core(input logic [6:0] latch, input logic [7:0] w);
		@(posedge ref_clk);
		core <= {latch, w};
		// let the value settle before the bench model reads it
		@(posedge ref_clk);
	endtask

	// context save on interrupt entry
	task automatic save(input pcs_ctx_t c);
		@(posedge ref_clk);
		ctx_save <= 1'b1;
		ctx_in <= c;
		@(posedge ref_clk);
		ctx_save <= 1'b0;
	endtask
endmodule // pcs_cpu_model

`default_nettype wire
